// [core/sse_core.sv]
/*
 * State-exit logic of a supply sequencing engine: state definition store,
 * sequence, monitor and timeout exits, fault latch, status and the
 * converter round-robin scheduler with averaging and limit warnings.
 * Assumes synchronous inputs on clk_in and a converter that presents a
 * stable 12-bit result on adc_result_in by the end of each conversion slot.
 */
`timescale 1ns/1ps
// Overview of operation
// - Sequence input at level advances to next
// - Sequence delay zero or 10us to 400ms
// - Level change during delay restarts timer
// - Monitor exit is undelayed OR of deviations
// - Each state change waits 20us to load
// - Timeout exit after 100us to 400ms
// - Driver levels fixed while in state
// - Fault latch bit per input, readable
// - Per-state latch enable keeps earlier faults
// - Live undervoltage, overvoltage, limit status
// - Scheduler covers twelve converter channels
// - Selected channels in turn, once or continuous
// - Averaging runs 16 passes, then writes results
// - Result is 12-bit unsigned code
// - One limit per channel, max or min
// - Beyond-limit result raises status and warning
// - Scheduler starts by write or state entry
// - Each channel conversion takes 500us
// - All warnings ORed into engine input
// - Host jump forces advance to next state
// - 63 states, any reachable from any
module sse_core
	import sse_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYCLES_DEF
)(
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic [7:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [31:0] rdata_out,
	input  wire logic [9:0]  supply_ok_in,
	input  wire logic [9:0]  uv_in,
	input  wire logic [9:0]  ov_in,
	input  wire logic [9:0]  secondary_warn_in,
	input  wire logic [11:0] adc_result_in,
	output logic      [9:0]  driver_output_out,
	output logic             adc_convert_out,
	output logic      [3:0]  adc_channel_out,
	output logic      [5:0]  state_out,
	output logic             warning_out
);
	if (CONV_CYCLES < 1 || CONV_CYCLES > 65536)
	begin : g_conv_check
		$error("CONV_CYCLES must lie in 1 to 65536");
	end

	localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);

	typedef struct packed {
		sse_eng_t                       eng;
		logic [5:0]                     cur;
		logic [5:0]                     nxt;
		logic [8:0]                     load_cnt;
		sse_def_t                       act;
		sse_def_t [NUM_STATES-1:0]      defs;
		logic [5:0]                     def_sel;
		logic [7:0]                     tick_cnt;
		logic [15:0]                    seq_cnt;
		logic [15:0]                    tmo_cnt;
		logic                           jump;
		logic [9:0]                     drv;
		logic [9:0]                     fault;
		sse_adc_t                       adc;
		logic [11:0]                    adc_mask;
		logic                           adc_cont;
		logic                           adc_avg;
		logic [3:0]                     ch;
		logic [3:0]                     pass;
		logic [15:0]                    conv_cnt;
		logic                           conv_go;
		logic [NUM_CH-1:0][15:0]        acc;
		logic [NUM_CH-1:0][11:0]        res;
		logic [NUM_CH-1:0][13:0]        lim;
		logic [NUM_CH-1:0]              warn;
		logic                           warn_any;
		logic [31:0]                    rdata;
	} sse_state_t;

	sse_state_t s;
	sse_state_t next_s;

	// Per-input deviation from the expected level, gated by the mask.
	function automatic logic [10:0] sse_dev(input logic [10:0] lvl, input logic [10:0] expv,
		input logic [10:0] mask);
		return (lvl ^ expv) & mask;
	endfunction

	// Zero means no delay; otherwise the programmed ticks are held within range.
	function automatic logic [15:0] sse_clamp(input logic [15:0] v, input logic [15:0] lo);
		logic [15:0] r;
		r = v;
		if (v != 16'h0 && v < lo)
			r = lo;
		else if (v > DLY_MAX_TICKS)
			r = DLY_MAX_TICKS;
		return r;
	endfunction

	logic [10:0] eng_in;
	logic [10:0] dev;
	logic        warn_any;

	assign warn_any = (|s.warn) | (|secondary_warn_in);
	assign eng_in = {warn_any, supply_ok_in};
	assign dev = sse_dev(eng_in, s.act.mon_exp, s.act.mon_mask);

	always_comb
	begin
		sse_def_t    d;
		logic [9:0]  fset;
		logic [9:0]  fclr;
		logic [15:0] seq_dly;
		logic [15:0] tmo_dly;
		logic        tick;
		logic        seq_hit;
		logic        seq_exit;
		logic        tmo_exit;
		logic        mon_exit;
		logic [5:0]  target;
		logic        adc_go;
		logic        step;
		logic        cycle_end;
		d = s.defs[s.def_sel];
		fset = 10'h0;
		fclr = 10'h0;
		seq_dly = sse_clamp(s.act.seq_dly, SEQ_MIN_TICKS);
		tmo_dly = sse_clamp(s.act.tmo_dly, TMO_MIN_TICKS);
		tick = (s.tick_cnt == TICK_LAST);
		seq_hit = 1'b0;
		seq_exit = 1'b0;
		tmo_exit = 1'b0;
		mon_exit = 1'b0;
		target = STATE_NONE;
		adc_go = 1'b0;
		step = 1'b0;
		cycle_end = 1'b0;
		next_s = s;
		next_s.conv_go = 1'b0;
		next_s.rdata = 32'h0;
		next_s.warn_any = warn_any;

		if (wr_in)
		begin
			case (addr_in)
				OFS_ENG_CTRL:
					if (wdata_in[CTRL_JUMP_BIT])
						next_s.jump = 1'b1;
				OFS_DEF_SEL:
					if (wdata_in[5:0] != STATE_NONE)
						next_s.def_sel = wdata_in[5:0];
				OFS_DEF_NEXT:
				begin
					d.seq_next = wdata_in[5:0];
					d.tmo_next = wdata_in[NXT_TMO_LSB +: 6];
					d.mon_next = wdata_in[NXT_MON_LSB +: 6];
					d.latch_en = wdata_in[NXT_LATCH_BIT];
					d.adc_en = wdata_in[NXT_ADC_BIT];
				end
				OFS_DEF_SEQ:
				begin
					d.seq_sel = wdata_in[3:0];
					d.seq_lvl = wdata_in[SEQ_LVL_BIT];
					d.seq_dly = wdata_in[SEQ_DLY_LSB +: 16];
				end
				OFS_DEF_TMO:
					d.tmo_dly = wdata_in[15:0];
				OFS_DEF_MON:
				begin
					d.mon_mask = wdata_in[10:0];
					d.mon_exp = wdata_in[MON_EXP_LSB +: 11];
				end
				OFS_DEF_OUT:
					d.drv = wdata_in[9:0];
				OFS_FAULT_LOW:
					fclr[4:0] = wdata_in[4:0];
				OFS_FAULT_HIGH:
					fclr[9:5] = wdata_in[4:0];
				OFS_ADC_CTRL:
				begin
					next_s.adc_mask = wdata_in[11:0];
					next_s.adc_cont = wdata_in[ADC_CONT_BIT];
					next_s.adc_avg = wdata_in[ADC_AVG_BIT];
					adc_go = wdata_in[ADC_GO_BIT];
				end
				default:
					if (addr_in[7:6] == REGION_LIMIT && addr_in[5:2] <= CH_LAST)
						next_s.lim[addr_in[5:2]] = {wdata_in[LIM_EN_BIT], wdata_in[LIM_MIN_BIT], wdata_in[11:0]};
			endcase
			next_s.defs[s.def_sel] = d;
		end

		if (rd_in)
		begin
			case (addr_in)
				OFS_ENG_CTRL:
					next_s.rdata = {23'h0, s.eng == ENG_LOAD, 2'h0, s.cur};
				OFS_DEF_SEL:
					next_s.rdata = {26'h0, s.def_sel};
				OFS_DEF_NEXT:
					next_s.rdata = {6'h0, d.adc_en, d.latch_en, 2'h0, d.mon_next, 2'h0, d.tmo_next, 2'h0, d.seq_next};
				OFS_DEF_SEQ:
					next_s.rdata = {d.seq_dly, 11'h0, d.seq_lvl, d.seq_sel};
				OFS_DEF_TMO:
					next_s.rdata = {16'h0, d.tmo_dly};
				OFS_DEF_MON:
					next_s.rdata = {5'h0, d.mon_exp, 5'h0, d.mon_mask};
				OFS_DEF_OUT:
					next_s.rdata = {22'h0, d.drv};
				OFS_FAULT_LOW:
					next_s.rdata = {27'h0, s.fault[4:0]};
				OFS_FAULT_HIGH:
					next_s.rdata = {27'h0, s.fault[9:5]};
				OFS_STAT_UV:
					next_s.rdata = {22'h0, uv_in};
				OFS_STAT_OV:
					next_s.rdata = {22'h0, ov_in};
				OFS_STAT_ADC:
					next_s.rdata = {20'h0, s.warn};
				OFS_ADC_CTRL:
					next_s.rdata = {12'h0, s.adc == ADC_BUSY, 1'b0, s.adc_avg, s.adc_cont, 4'h0, s.adc_mask};
				default:
					if (addr_in[7:6] == REGION_RESULT && addr_in[5:2] <= CH_LAST)
						next_s.rdata = {20'h0, s.res[addr_in[5:2]]};
					else if (addr_in[7:6] == REGION_LIMIT && addr_in[5:2] <= CH_LAST)
						next_s.rdata = {14'h0, s.lim[addr_in[5:2]][13:12], 4'h0, s.lim[addr_in[5:2]][11:0]};
			endcase
		end

		unique case (s.eng)
			ENG_RUN:
			begin
				next_s.tick_cnt = tick ? 8'h0 : s.tick_cnt + 8'h1;
				seq_hit = s.act.seq_sel <= SEL_WARN && eng_in[s.act.seq_sel] == s.act.seq_lvl;
				if (!seq_hit)
					next_s.seq_cnt = 16'h0;
				else if (tick && s.seq_cnt < seq_dly)
					next_s.seq_cnt = s.seq_cnt + 16'h1;
				seq_exit = seq_hit && s.seq_cnt >= seq_dly;
				if (tick && s.tmo_cnt < tmo_dly)
					next_s.tmo_cnt = s.tmo_cnt + 16'h1;
				tmo_exit = tmo_dly != 16'h0 && s.tmo_cnt >= tmo_dly;
				mon_exit = |dev;
				if (mon_exit)
					target = s.act.mon_next;
				else if (tmo_exit)
					target = s.act.tmo_next;
				else if (seq_exit || s.jump)
					// jump acts as a sequence exit
					target = s.act.seq_next;
				if (target != STATE_NONE)
				begin
					next_s.eng = ENG_LOAD;
					next_s.nxt = target;
					next_s.load_cnt = 9'h0;
				end
				if (mon_exit || tmo_exit || seq_exit || s.jump)
					next_s.jump = 1'b0;
				if (s.act.latch_en)
					fset = dev[9:0];
			end
			ENG_LOAD:
			begin
				next_s.load_cnt = s.load_cnt + 9'h1;
				if (s.load_cnt == LOAD_LAST)
				begin
					next_s.eng = ENG_RUN;
					next_s.cur = s.nxt;
					next_s.act = s.defs[s.nxt];
					next_s.drv = s.defs[s.nxt].drv;
					next_s.tick_cnt = 8'h0;
					next_s.seq_cnt = 16'h0;
					next_s.tmo_cnt = 16'h0;
					if (s.defs[s.nxt].adc_en)
						adc_go = 1'b1;
				end
			end
		endcase

		// a new fault wins over a clear
		next_s.fault = (s.fault & ~fclr) | fset;

		if (s.adc == ADC_BUSY)
		begin
			if (!s.adc_mask[s.ch])
				step = 1'b1;
			else
			begin
				next_s.conv_go = s.conv_cnt == 16'h0;
				if (s.conv_cnt == CONV_LAST)
				begin
					next_s.conv_cnt = 16'h0;
					step = 1'b1;
					if (s.adc_avg)
						next_s.acc[s.ch] = s.acc[s.ch] + {4'h0, adc_result_in};
					else
						next_s.res[s.ch] = adc_result_in;
				end
				else
					next_s.conv_cnt = s.conv_cnt + 16'h1;
			end
			if (step)
			begin
				if (s.ch == CH_LAST)
				begin
					next_s.ch = 4'h0;
					cycle_end = !s.adc_avg;
					if (s.adc_avg)
					begin
						next_s.pass = s.pass + 4'h1;
						if (s.pass == PASS_LAST)
						begin
							cycle_end = 1'b1;
							for (int c = 0; c < NUM_CH; c++)
							begin
								if (s.adc_mask[c])
									next_s.res[c] = next_s.acc[c][15:4];
								next_s.acc[c] = 16'h0;
							end
						end
					end
					if (cycle_end && !s.adc_cont)
						next_s.adc = ADC_IDLE;
				end
				else
					next_s.ch = s.ch + 4'h1;
			end
		end

		if (adc_go)
		begin
			next_s.adc = ADC_BUSY;
			next_s.ch = 4'h0;
			next_s.pass = 4'h0;
			next_s.conv_cnt = 16'h0;
			next_s.acc = '0;
		end

		for (int c = 0; c < NUM_CH; c++)
			next_s.warn[c] = s.lim[c][13] && (s.lim[c][12] ? s.res[c] < s.lim[c][11:0] : s.res[c] > s.lim[c][11:0]);
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			s <= '0;
			s.eng <= ENG_LOAD;
			s.adc <= ADC_IDLE;
		end
		else
			s <= next_s;
	end

	// A load after reset brings in state 0, so outputs settle from its definition.
	assign rdata_out = s.rdata;
	assign driver_output_out = s.drv;
	assign adc_convert_out = s.conv_go;
	assign adc_channel_out = s.ch;
	assign state_out = s.cur;
	assign warning_out = s.warn_any;
endmodule

// [core/sse_pkg.sv]
/*
 * Constants, field layout and types of the supply sequencer state-exit block.
 * Assumes a 20 MHz system clock; times are converted to cycles, or to 10us ticks for the delay limits, here.
 */
package sse_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int LOAD_TIME_NS  = 20000;
	localparam int LOAD_CYCLES   = LOAD_TIME_NS / CLK_PERIOD_NS;
	localparam int TICK_TIME_NS  = 10000;
	localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
	localparam int TMO_MIN_NS    = 100000;
	localparam int DLY_MAX_NS    = 400000000;
	localparam int CONV_TIME_NS  = 500000;
	localparam int CONV_CYCLES_DEF = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam logic [8:0]  LOAD_LAST     = 9'(LOAD_CYCLES - 1);
	localparam logic [7:0]  TICK_LAST     = 8'(TICK_CYCLES - 1);
	localparam logic [15:0] SEQ_MIN_TICKS = 16'h0001;
	localparam logic [15:0] TMO_MIN_TICKS = 16'(TMO_MIN_NS / TICK_TIME_NS);
	localparam logic [15:0] DLY_MAX_TICKS = 16'(DLY_MAX_NS / TICK_TIME_NS);
	localparam int NUM_STATES = 63;
	localparam int NUM_IN     = 10;
	localparam int NUM_CH     = 12;
	localparam logic [5:0]  STATE_NONE = 6'h3f;
	localparam logic [3:0]  SEL_WARN   = 4'ha;
	localparam logic [3:0]  CH_LAST    = 4'hb;
	localparam logic [3:0]  PASS_LAST  = 4'hf;
	localparam logic [7:0] OFS_ENG_CTRL   = 8'h00;
	localparam logic [7:0] OFS_DEF_SEL    = 8'h04;
	localparam logic [7:0] OFS_DEF_NEXT   = 8'h08;
	localparam logic [7:0] OFS_DEF_SEQ    = 8'h0c;
	localparam logic [7:0] OFS_DEF_TMO    = 8'h10;
	localparam logic [7:0] OFS_DEF_MON    = 8'h14;
	localparam logic [7:0] OFS_DEF_OUT    = 8'h18;
	localparam logic [7:0] OFS_FAULT_LOW  = 8'h1c;
	localparam logic [7:0] OFS_FAULT_HIGH = 8'h20;
	localparam logic [7:0] OFS_STAT_UV    = 8'h24;
	localparam logic [7:0] OFS_STAT_OV    = 8'h28;
	localparam logic [7:0] OFS_STAT_ADC   = 8'h2c;
	localparam logic [7:0] OFS_ADC_CTRL   = 8'h30;
	localparam logic [1:0] REGION_RESULT  = 2'h1;
	localparam logic [1:0] REGION_LIMIT   = 2'h2;
	localparam int CTRL_JUMP_BIT = 0;
	localparam int STAT_LOAD_BIT = 8;
	localparam int NXT_TMO_LSB   = 8;
	localparam int NXT_MON_LSB   = 16;
	localparam int NXT_LATCH_BIT = 24;
	localparam int NXT_ADC_BIT   = 25;
	localparam int SEQ_LVL_BIT   = 4;
	localparam int SEQ_DLY_LSB   = 16;
	localparam int MON_EXP_LSB   = 16;
	localparam int ADC_CONT_BIT  = 16;
	localparam int ADC_AVG_BIT   = 17;
	localparam int ADC_GO_BIT    = 18;
	localparam int ADC_RUN_BIT   = 19;
	localparam int LIM_MIN_BIT   = 16;
	localparam int LIM_EN_BIT    = 17;
	typedef enum logic {ENG_LOAD = 1'b0, ENG_RUN = 1'b1} sse_eng_t;
	typedef enum logic {ADC_IDLE = 1'b0, ADC_BUSY = 1'b1} sse_adc_t;
	typedef struct packed {
		logic [5:0]  seq_next;
		logic [5:0]  tmo_next;
		logic [5:0]  mon_next;
		logic        latch_en;
		logic        adc_en;
		logic [3:0]  seq_sel;
		logic        seq_lvl;
		logic [15:0] seq_dly;
		logic [15:0] tmo_dly;
		logic [10:0] mon_mask;
		logic [10:0] mon_exp;
		logic [9:0]  drv;
	} sse_def_t;
endpackage

// [tb/sse_props.sv]
/*
 * Port-level assertions for the supply sequencer state-exit core.
 * Assumes binding to sse_core on one clock with synchronous reset.
 */
`timescale 1ns/1ps
module sse_props
	import sse_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYCLES_DEF
)(
	input wire logic        clk_in,
	input wire logic        reset_in,
	input wire logic [7:0]  addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic [31:0] rdata_out,
	input wire logic [9:0]  supply_ok_in,
	input wire logic [9:0]  uv_in,
	input wire logic [9:0]  ov_in,
	input wire logic [9:0]  secondary_warn_in,
	input wire logic [11:0] adc_result_in,
	input wire logic [9:0]  driver_output_out,
	input wire logic        adc_convert_out,
	input wire logic [3:0]  adc_channel_out,
	input wire logic [5:0]  state_out,
	input wire logic        warning_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	logic [5:0]  prev_state;
	logic [15:0] since_chg;
	logic [15:0] since_conv;
	logic        booted;
	// Saturating counters keep long idle spans from wrapping into false gaps.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			prev_state <= 6'h00;
			since_chg  <= 16'h0000;
			since_conv <= 16'hffff;
			booted     <= 1'b0;
		end
		else
		begin
			prev_state <= state_out;
			since_chg  <= (state_out != prev_state) ? 16'h0000 : since_chg + 16'((since_chg != 16'hffff));
			since_conv <= adc_convert_out ? 16'h0000 : since_conv + 16'((since_conv != 16'hffff));
			// The first load after reset sets the drivers without a change of state index.
			booted     <= booted | (since_chg > 16'(LOAD_CYCLES));
		end
	end
	AST_RD_IDLE: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
		else $error("read data not zero outside read slot");
	AST_RD_STATUS: assert property (rd_in && addr_in == OFS_STAT_UV |=> rdata_out == {22'h0, $past(uv_in)})
		else $error("undervoltage status not live");
	AST_CONV_PULSE: assert property (adc_convert_out |=> !adc_convert_out)
		else $error("convert pulse longer than one cycle");
	AST_CONV_GAP: assert property (adc_convert_out |-> since_conv >= 16'(CONV_CYCLES - 1))
		else $error("conversion slot too short");
	AST_CONV_CHAN: assert property (adc_convert_out |=> $stable(adc_channel_out) [*5])
		else $error("channel changed inside slot");
	AST_CHAN_RANGE: assert property (adc_channel_out <= CH_LAST)
		else $error("channel index out of range");
	AST_DRV_HOLD: assert property (booted && state_out == prev_state |-> $stable(driver_output_out))
		else $error("drivers changed within a state");
	AST_LOAD_TIME: assert property (state_out != prev_state |-> since_chg >= 16'h0190)
		else $error("state change faster than load time");
	AST_WARN_SEC: assert property (|secondary_warn_in |=> warning_out)
		else $error("secondary warning not merged");
endmodule

// [tb/sse_adc_model.sv]
/*
 * Converter model: returns a channel-dependent code at each convert pulse.
 * Assumes the core samples the code late in each slot.
 */
`timescale 1ns/1ps
module sse_adc_model (
	input  wire logic        clk_in,
	input  wire logic        adc_convert_in,
	input  wire logic [3:0]  adc_channel_in,
	output logic      [11:0] adc_result_out
);
	always_ff @(posedge clk_in)
	begin
		if (adc_convert_in)
			adc_result_out <= {adc_channel_in, 8'h5a};
	end
endmodule

// [tb/tb_supply_sequencer_state_exits.sv]
/*
 * Self-checking bench for the state-exit core with a converter model.
 * Assumes a shortened conversion slot of 8 cycles.
 */
`timescale 1ns/1ps
module tb_supply_sequencer_state_exits;
	import sse_pkg::*;
	logic        clk_in, reset_in, wr_in, rd_in, adc_convert_out, warning_out;
	logic [7:0]  addr_in;
	logic [31:0] wdata_in, rdata_out, d;
	logic [9:0]  supply_ok_in, uv_in, ov_in, secondary_warn_in, driver_output_out;
	logic [11:0] adc_result_in;
	logic [3:0]  adc_channel_out;
	logic [5:0]  state_out;
	int          errors, n_tests, n_conv, cnt;
	sse_core #(.CONV_CYCLES(8)) i_sse_core (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .supply_ok_in(supply_ok_in),
		.uv_in(uv_in), .ov_in(ov_in), .secondary_warn_in(secondary_warn_in), .adc_result_in(adc_result_in),
		.driver_output_out(driver_output_out), .adc_convert_out(adc_convert_out),
		.adc_channel_out(adc_channel_out), .state_out(state_out), .warning_out(warning_out));
	sse_adc_model i_sse_adc_model (.clk_in(clk_in), .adc_convert_in(adc_convert_out),
		.adc_channel_in(adc_channel_out), .adc_result_out(adc_result_in));
	initial
	begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	always @(posedge clk_in)
		if (adc_convert_out === 1'b1)
			n_conv++;
	task automatic test_done();
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_in);
		addr_in  <= a;
		wdata_in <= v;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 v = rdata_out;
	endtask
	task automatic wait_state(input logic [5:0] s, input int lim);
		cnt = 0;
		while (state_out !== s && cnt < lim)
		begin
			@(posedge clk_in);
			#1 cnt++;
		end
		if (state_out !== s)
		begin
			errors++;
			test_done();
		end
	endtask
	task automatic defn(input logic [5:0] i, input logic [31:0] nx, sq, tm, mn, ou);
		wr(OFS_DEF_SEL, {26'h0, i});
		wr(OFS_DEF_NEXT, nx);
		wr(OFS_DEF_SEQ, sq);
		wr(OFS_DEF_TMO, tm);
		wr(OFS_DEF_MON, mn);
		wr(OFS_DEF_OUT, ou);
	endtask
	task automatic t_seq();
		supply_ok_in <= 10'h001;
		wait_state(6'h01, 600);
		chk("seq load time", 32'((cnt >= 400) && (cnt <= 404)), 32'h1);
		chk("state one drivers", {22'h0, driver_output_out}, 32'h2a5);
	endtask
	task automatic t_delay();
		supply_ok_in <= 10'h003;
		repeat (600) @(posedge clk_in);
		supply_ok_in <= 10'h001;
		@(posedge clk_in);
		supply_ok_in <= 10'h003;
		repeat (900) @(posedge clk_in);
		#1 chk("timer restarted", {26'h0, state_out}, 32'h1);
		wait_state(6'h02, 1500);
	endtask
	task automatic t_prio();
		@(posedge clk_in);
		supply_ok_in <= 10'h002;
		wait_state(6'h03, 600);
		chk("monitor wins", {26'h0, state_out}, 32'h3);
		@(posedge clk_in);
		supply_ok_in <= 10'h003;
	endtask
	task automatic t_tmo();
		wait_state(6'h04, 3000);
		chk("timeout span", 32'((cnt >= 2200) && (cnt <= 2700)), 32'h1);
		rd(OFS_FAULT_LOW, d);
		chk("fault kept", d, 32'h1);
		rd(OFS_FAULT_HIGH, d);
		chk("no high fault", d, 32'h0);
		wr(OFS_FAULT_LOW, 32'h1);
		rd(OFS_FAULT_LOW, d);
		chk("fault cleared", d, 32'h0);
	endtask
	task automatic t_adc();
		cnt = 0;
		d = 32'h0008_0000;
		while (d[ADC_RUN_BIT] !== 1'b0 && cnt < 500)
		begin
			rd(OFS_ADC_CTRL, d);
			cnt++;
		end
		chk("scheduler idle", {31'h0, d[ADC_RUN_BIT]}, 32'h0);
	endtask
	task automatic t_results();
		repeat (4) @(posedge clk_in);
		t_adc();
		chk("pulses one pass", 32'(n_conv), 32'h2);
		rd(8'h40, d);
		chk("result ch0", d, 32'h05a);
		rd(8'h48, d);
		chk("result ch2", d, 32'h25a);
		rd(OFS_STAT_ADC, d);
		chk("limit warning", d, 32'h001);
		chk("warning out", {31'h0, warning_out}, 32'h1);
		n_conv = 0;
		wr(OFS_ADC_CTRL, 32'h0006_0002);
		repeat (4) @(posedge clk_in);
		t_adc();
		chk("average passes", 32'(n_conv), 32'h10);
		rd(8'h44, d);
		chk("average result", d, 32'h15a);
	endtask
	task automatic t_jump();
		wr(OFS_ENG_CTRL, 32'h1);
		wait_state(6'h05, 600);
		chk("jump drivers", {22'h0, driver_output_out}, 32'h3ff);
		rd(OFS_STAT_OV, d);
		chk("overvoltage status", d, 32'h2aa);
		rd(8'hfc, d);
		chk("unmapped read", d, 32'h0);
		wr(8'h80, 32'h0);
		repeat (3) @(posedge clk_in);
		#1 chk("warning quiet", {31'h0, warning_out}, 32'h0);
		@(posedge clk_in);
		secondary_warn_in <= 10'h200;
		@(posedge clk_in);
		#1 chk("secondary warning", {31'h0, warning_out}, 32'h1);
		@(posedge clk_in);
		secondary_warn_in <= 10'h000;
	endtask
	initial
	begin
		{reset_in, wr_in, rd_in, addr_in, wdata_in} = {1'b1, 42'h0};
		{supply_ok_in, secondary_warn_in, n_conv} = 0;
		{uv_in, ov_in, errors, n_tests} = {10'h155, 10'h2aa, 64'h0};
		repeat (20) @(posedge clk_in);
		reset_in <= 1'b0;
		#1 chk("reset drivers", {22'h0, driver_output_out}, 32'h0);
		defn(6'h00, 32'h0000_0001, 32'h0000_0010, 32'h0, 32'h0, 32'h001);
		defn(6'h01, 32'h0000_0002, 32'h0004_0011, 32'h0, 32'h0, 32'h2a5);
		defn(6'h02, 32'h0103_0005, 32'h0, 32'h0, 32'h0001_0001, 32'h0f0);
		defn(6'h03, 32'h0000_0400, 32'h0000_000f, 32'h0000_000a, 32'h0, 32'h300);
		defn(6'h04, 32'h0200_0005, 32'h0000_000f, 32'h0, 32'h0, 32'h00c);
		defn(6'h05, 32'h0000_0005, 32'h0000_000f, 32'h0, 32'h0, 32'h3ff);
		wr(8'h80, 32'h0002_0050);
		wr(OFS_ADC_CTRL, 32'h0000_0005);
		repeat (400) @(posedge clk_in);
		t_seq();
		t_delay();
		t_prio();
		n_conv = 0;
		t_tmo();
		t_results();
		t_jump();
		test_done();
	end
endmodule

bind sse_core sse_props #(.CONV_CYCLES(CONV_CYCLES)) i_sse_props (.clk_in(clk_in), .reset_in(reset_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
	.supply_ok_in(supply_ok_in), .uv_in(uv_in), .ov_in(ov_in), .secondary_warn_in(secondary_warn_in),
	.adc_result_in(adc_result_in), .driver_output_out(driver_output_out), .adc_convert_out(adc_convert_out),
	.adc_channel_out(adc_channel_out), .state_out(state_out), .warning_out(warning_out));
